// >>> bench/kat_model.sv
/* self-test engine model; assumes one start pulse per test run */
`timescale 1ns/1ns
module kat_model (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       kat_start,
    input wire logic       pass_cfg,
    input wire logic [3:0] dly,
    output logic           kat_done,
    output logic           kat_pass
);
    int cnt_q;
    // ==========================================
    // verdict dly+1 cycles after the start is sampled; pass line inverted outside the pulse
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 0;
            kat_done <= 1'b0;
            kat_pass <= 1'b0;
        end else begin
            cnt_q <= kat_start ? dly + 1 : (cnt_q > 0 ? cnt_q - 1 : 0);
            kat_done <= (cnt_q == 1);
            kat_pass <= (cnt_q == 1) ? pass_cfg : ~pass_cfg;
        end
    end
endmodule : kat_model

// >>> bench/kss_properties.sv
/* port checker for the key store; bound to every instance below */
`timescale 1ns/1ns
module kss_properties
    import kss_pkg::*;
#(
    parameter int CH = CHANNELS,
    parameter int HW = HASH_W
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              bus_req,
    input wire logic              bus_we,
    input wire logic              bus_ack,
    input wire logic              bus_err,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic              acr_req,
    input wire logic              kat_start,
    input wire logic              op_req,
    input wire logic              op_grant,
    input wire logic [CH-1:0]     key_loaded,
    input wire logic              ready,
    input wire logic              locked,
    input wire logic              hash_valid,
    input wire logic [HW-1:0]     image_hash,
    input wire logic [HW-1:0]     otp_hash,
    input wire logic              hash_checked,
    input wire logic              key_verified
);
    // ==========================================
    // host port, gates and clearing
    req_ack_a:
        assert property (@(posedge clk) disable iff (!rstn) bus_req |=> bus_ack)
        else $error("request without ack");
    read_zero_a:
        assert property (@(posedge clk) disable iff (!rstn)
            bus_req && !bus_we |=> bus_ack && !bus_err && bus_rdata == '0)
        else $error("read not answered with zeros");
    rdata_quiet_a:
        assert property (@(posedge clk) disable iff (!rstn) bus_rdata == '0)
        else $error("read data not zero");
    early_write_a:
        assert property (@(posedge clk) disable iff (!rstn)
            bus_req && bus_we && !ready |=> bus_ack && bus_err)
        else $error("write accepted before ready");
    acr_clear_a:
        assert property (@(posedge clk) disable iff (!rstn)
            acr_req |=> !ready && key_loaded == '0 && !key_verified)
        else $error("reset event left state behind");
    sweep_first_a:
        assert property (@(posedge clk) disable iff (!rstn)
            acr_req |=> !kat_start [*3] ##[1:3] kat_start)
        else $error("self-test start out of place");
    grant_gate_a:
        assert property (@(posedge clk) disable iff (!rstn)
            op_grant |-> $past(op_req) && $past(ready))
        else $error("grant without ready request");
    lock_hold_a:
        assert property (@(posedge clk) disable iff (!rstn)
            locked && !acr_req |=> locked && !ready && !op_grant)
        else $error("lock released without reset");
    digest_cmp_a:
        assert property (@(posedge clk) disable iff (!rstn)
            hash_valid && !acr_req |=> hash_checked
            && key_verified == ($past(image_hash) == $past(otp_hash)))
        else $error("digest verdict wrong");
endmodule : kss_properties

bind secure_key_store kss_properties #(.CH(CH), .HW(HW)) u_kss_properties (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_we(bus_we), .bus_ack(bus_ack),
    .bus_err(bus_err), .bus_rdata(bus_rdata), .acr_req(acr_req), .kat_start(kat_start),
    .op_req(op_req), .op_grant(op_grant), .key_loaded(key_loaded), .ready(ready),
    .locked(locked), .hash_valid(hash_valid), .image_hash(image_hash),
    .otp_hash(otp_hash), .hash_checked(hash_checked), .key_verified(key_verified));

// >>> bench/test_secure_key_store.sv
/* bench for the key store; drives the host side, checks the ports */
`timescale 1ns/1ns
module test_secure_key_store;
    import kss_pkg::*;
    logic clk = 0, rstn = 0, bus_req = 0, bus_we = 0, acr_req = 0, op_req = 0;
    logic hash_valid = 0, pass_cfg = 1, kat_start, kat_done, kat_pass;
    logic bus_ack, bus_err, op_grant, ready, locked, hash_checked, key_verified;
    logic [7:0] bus_addr = 0, chan_owner = 8'hE4;
    logic [31:0] bus_wdata = 0, bus_rdata;
    logic [1:0] bus_use = 0, op_chan = 0;
    logic [3:0] key_loaded, dly = 4'h2;
    logic [255:0] image_hash = 0, otp_hash = 0;
    int failures = 0, total_checks = 0;

    always #2 clk = ~clk;

    secure_key_store u_secure_key_store (.clk(clk), .rstn(rstn), .bus_req(bus_req),
        .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_use(bus_use),
        .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata),
        .chan_owner(chan_owner), .acr_req(acr_req), .kat_start(kat_start),
        .kat_done(kat_done), .kat_pass(kat_pass), .op_req(op_req), .op_chan(op_chan),
        .op_grant(op_grant), .key_loaded(key_loaded), .ready(ready), .locked(locked),
        .hash_valid(hash_valid), .image_hash(image_hash), .otp_hash(otp_hash),
        .hash_checked(hash_checked), .key_verified(key_verified));
    kat_model u_kat_model (.clk(clk), .rstn(rstn), .kat_start(kat_start),
        .pass_cfg(pass_cfg), .dly(dly), .kat_done(kat_done), .kat_pass(kat_pass));

    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one access, then ack, error and zero data one cycle later
    task automatic xfer(input logic we, input logic [7:0] a, input logic [1:0] u,
                        input logic err);
        @(posedge clk);
        #1;
        bus_req = 1;
        bus_we = we;
        bus_addr = a;
        bus_use = u;
        bus_wdata = {24'hC35A96, a};
        @(posedge clk);
        #1;
        bus_req = 0;
        check(bus_ack, 1);
        check(bus_err, err);
        check(bus_rdata, 0);
    endtask : xfer
    task automatic op(input logic [1:0] c, input logic exp);
        @(posedge clk);
        #1;
        op_req = 1;
        op_chan = c;
        @(posedge clk);
        #1;
        op_req = 0;
        check(op_grant, exp);
    endtask : op
    // bounded wait for the end of the self-test
    task automatic settle(input logic lock);
        int n = 0;
        while (ready !== 1'b1 && locked !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(locked, lock);
        check(ready, !lock);
    endtask : settle
    task automatic load(input logic [1:0] c);
        for (int i = 0; i < SLOT_WORDS; i++) begin
            xfer(1, FIFO_BASE + 8'(c), c, 0);
            check(key_loaded[c], i == SLOT_WORDS - 1);
        end
    endtask : load
    task automatic reset_event;
        @(posedge clk);
        #1;
        acr_req = 1;
        @(posedge clk);
        #1;
        acr_req = 0;
        check(ready, 0);
        check(key_loaded, 0);
        check(key_verified, 0);
    endtask : reset_event
    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // ==========================================
    // scenarios
    task automatic t_start;
        xfer(1, FIFO_BASE, 0, 1);
        settle(0);
        load(0);
        op(0, 1);
        op(1, 0);
    endtask : t_start
    task automatic t_refuse;
        xfer(1, FIFO_BASE + 8'h01, 0, 1);
        check(key_loaded[1], 0);
        // a refused word that landed would fill the slot one word early
        load(1);
        // ownership follows the input, not a fixed map
        chan_owner = 8'h24;
        xfer(1, FIFO_BASE + 8'h03, 3, 1);
        xfer(1, FIFO_BASE + 8'h03, 0, 0);
        chan_owner = 8'hE4;
        xfer(1, 8'h10, 0, 1);
        xfer(1, KREG_BASE + 8'h07, 2, 0);
        xfer(0, KREG_BASE + 8'h07, 0, 0);
        xfer(0, FIFO_BASE, 0, 0);
        xfer(1, FIFO_BASE, 0, 0);
        check(key_loaded[0], 0);
    endtask : t_refuse
    task automatic t_hash;
        @(posedge clk);
        #1;
        hash_valid = 1;
        image_hash = {8{32'h3C5A96E1}};
        otp_hash = ~image_hash;
        @(posedge clk);
        #1;
        otp_hash = image_hash;
        check(key_verified, 0);
        @(posedge clk);
        #1;
        hash_valid = 0;
        check(hash_checked, 1);
        check(key_verified, 1);
    endtask : t_hash
    task automatic t_lock;
        dly = 4'h9;
        // the preceding reset event leaves the store sweeping, not ready
        settle(0);
        load(2);
        reset_event();
        settle(0);
        op(2, 0);
        pass_cfg = 0;
        reset_event();
        settle(1);
        xfer(1, KREG_BASE, 0, 1);
        pass_cfg = 1;
        reset_event();
        settle(0);
    endtask : t_lock
    // pin reset in mid-run: loaded key gone, sweep and tests again
    task automatic t_rst;
        load(3);
        @(posedge clk);
        #1;
        rstn = 0;
        @(posedge clk);
        #1;
        check(key_loaded, 0);
        check(ready, 0);
        rstn = 1;
        settle(0);
        op(3, 0);
    endtask : t_rst

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rstn = 1;
        repeat (3) @(posedge clk);
        t_start();
        t_refuse();
        t_hash();
        reset_event();
        t_lock();
        t_rst();
        wrap_up();
    end
    // watchdog well past the expected run
    initial begin
        #20000;
        failures++;
        wrap_up();
    end
endmodule : test_secure_key_store

// >>> hdl/hash_match.sv
/*
 * Compares the digest of the public key carried with an image against
 * the one-time-programmed digest and holds the verdict.
 * Assumes the digest is computed outside and the programmed digest
 * arrives on a read-only input with no write path back.
 */
`timescale 1ns/1ns

module hash_match
    import kss_pkg::*;
#(
    parameter int HW = HASH_W
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          clr,
    input  wire logic          hash_valid,
    input  wire logic [HW-1:0] image_hash,
    input  wire logic [HW-1:0] otp_hash,
    output logic               checked,
    output logic               verified
);

    // ==================================================================
    // state
    typedef struct packed {
        logic checked;
        logic verified;
    } match_s;

    match_s q;
    match_s d;

    // verdict follows each new digest; a reset event drops it
    always_comb begin
        d = q;
        if (clr) begin
            d = '0;
        end else if (hash_valid) begin
            d.checked  = 1'b1;
            d.verified = (image_hash == otp_hash);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // the programmed digest is only ever compared, never stored or written
    assign checked  = q.checked;
    assign verified = q.verified;

endmodule : hash_match

// >>> hdl/kss_pkg.sv
/*
 * Constants shared by the key store: address map, sizes, phases.
 * Assumes nothing of its surroundings; imported whole by each module except kat_model.
 */
package kss_pkg;

    // ==================================================================
    // sizes
    localparam int DATA_W     = 32;   // host word
    localparam int ADDR_W     = 8;    // host word address
    localparam int USE_W      = 2;    // use-case identifier width
    localparam int KREG_WORDS = 8;    // write-only key register words
    localparam int CHANNELS   = 4;    // key-load channels, one slot each
    localparam int SLOT_WORDS = 8;    // words per key store slot
    localparam int HASH_W     = 256;  // public-key digest width

    // ==================================================================
    // address map (word addresses)
    localparam logic [7:0] KREG_BASE = 8'h00;  // key registers
    localparam logic [7:0] FIFO_BASE = 8'h20;  // one push address per channel

    // ==================================================================
    // phases of the store
    typedef enum logic [1:0] {
        ST_ZERO  = 2'b00,  // zeroize sweep
        ST_TEST  = 2'b01,  // waiting on power-up self-tests
        ST_READY = 2'b10,  // open for key loads and operations
        ST_LOCK  = 2'b11   // self-test failed, closed until reset
    } phase_e;

endpackage : kss_pkg

// >>> hdl/secure_key_store.sv
/*
 * Key and sensitive_parameter store of a cipher core: write-only key
 * registers, per-channel key slots loaded by the owning use case,
 * zeroize sweep on every reset event, self-test gate, digest check.
 * Assumes a host port synchronous to clk, an outside self-test engine
 * and an outside digest engine; owner assignment is a static input.
 */
`timescale 1ns/1ns

module secure_key_store
    import kss_pkg::*;
#(
    parameter int CH  = CHANNELS,
    parameter int SW  = SLOT_WORDS,
    parameter int KW  = KREG_WORDS,
    parameter int HW  = HASH_W
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // host port
    input  wire logic                  bus_req,
    input  wire logic                  bus_we,
    input  wire logic [ADDR_W-1:0]     bus_addr,
    input  wire logic [DATA_W-1:0]     bus_wdata,
    input  wire logic [USE_W-1:0]      bus_use,
    output logic                       bus_ack,
    output logic                       bus_err,
    output logic [DATA_W-1:0]          bus_rdata,
    // channel ownership, USE_W bits per channel
    input  wire logic [CH*USE_W-1:0]   chan_owner,
    // access-control reset event
    input  wire logic                  acr_req,
    // self-test engine
    output logic                       kat_start,
    input  wire logic                  kat_done,
    input  wire logic                  kat_pass,
    // cipher operation gate
    input  wire logic                  op_req,
    input  wire logic [$clog2(CH > 1 ? CH : 2)-1:0] op_chan,
    output logic                       op_grant,
    output logic [CH-1:0]              key_loaded,
    // status
    output logic                       ready,
    output logic                       locked,
    // image key check
    input  wire logic                  hash_valid,
    input  wire logic [HW-1:0]         image_hash,
    input  wire logic [HW-1:0]         otp_hash,
    output logic                       hash_checked,
    output logic                       key_verified
);

    localparam int CH_W = $clog2(CH > 1 ? CH : 2);
    localparam int PT_W = $clog2(SW > 1 ? SW : 2);
    localparam int KI_W = $clog2(KW > 1 ? KW : 2);

    // ==================================================================
    // reset release through two flops
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ==================================================================
    // state
    typedef struct packed {
        phase_e                           phase;
        logic [CH_W-1:0]                  zcnt;
        logic                             kat_start;
        logic                             ack;
        logic                             err;
        logic [DATA_W-1:0]                rdata;
        logic                             grant;
        logic [KW-1:0][DATA_W-1:0]        kreg;
        logic [CH-1:0][SW-1:0][DATA_W-1:0] slot;
        logic [CH-1:0][PT_W-1:0]          ptr;
        logic [CH-1:0]                    full;
    } store_s;

    store_s q;
    store_s d;

    // ==================================================================
    // address decode and ownership
    logic [ADDR_W-1:0] kofs;
    logic [ADDR_W-1:0] fofs;
    logic              khit;
    logic              fhit;
    logic [CH-1:0]     own_ok;
    logic [CH_W-1:0]   fidx;

    assign kofs = bus_addr - KREG_BASE;
    assign fofs = bus_addr - FIFO_BASE;
    assign khit = (bus_addr >= KREG_BASE) && (kofs < ADDR_W'(KW));
    assign fhit = (bus_addr >= FIFO_BASE) && (fofs < ADDR_W'(CH));
    assign fidx = fofs[CH_W-1:0];

    // each channel accepts only the use case it is assigned to
    for (genvar c = 0; c < CH; c++) begin : g_owner
        assign own_ok[c] = (chan_owner[c*USE_W +: USE_W] == bus_use);
    end

    // ==================================================================
    // next state
    always_comb begin
        d           = q;
        d.ack       = 1'b0;
        d.err       = 1'b0;
        d.rdata     = '0;
        d.kat_start = 1'b0;
        d.grant     = 1'b0;

        case (q.phase)
            // one slot per cycle; slots stay RAM-shaped for a real array
            ST_ZERO: begin
                d.kreg          = '0;
                d.slot[q.zcnt]  = '0;
                d.ptr[q.zcnt]   = '0;
                d.full[q.zcnt]  = 1'b0;
                if (q.zcnt == CH_W'(CH - 1)) begin
                    d.zcnt      = '0;
                    d.phase     = ST_TEST;
                    d.kat_start = 1'b1;
                end else begin
                    d.zcnt = q.zcnt + CH_W'(1);
                end
            end
            ST_TEST: begin
                if (kat_done) begin
                    d.phase = kat_pass ? ST_READY : ST_LOCK;
                end
            end
            ST_READY: begin
                // operations only on a completely loaded slot
                d.grant = op_req && q.full[op_chan];
            end
            ST_LOCK: begin
                d.phase = ST_LOCK;
            end
            default: begin
                d.phase = ST_ZERO;
                d.zcnt  = '0;
            end
        endcase

        // host port: every access is answered the next cycle
        if (bus_req) begin
            d.ack = 1'b1;
            if (!bus_we) begin
                d.rdata = '0;
            end else if (q.phase != ST_READY) begin
                d.err = 1'b1;
            end else if (khit) begin
                d.kreg[kofs[KI_W-1:0]] = bus_wdata;
            end else if (fhit && own_ok[fidx]) begin
                // first word of a key wipes the slot, no stale tail
                if (q.ptr[fidx] == '0) begin
                    d.slot[fidx] = '0;
                    d.full[fidx] = 1'b0;
                end
                d.slot[fidx][q.ptr[fidx]] = bus_wdata;
                if (q.ptr[fidx] == PT_W'(SW - 1)) begin
                    d.ptr[fidx]  = '0;
                    d.full[fidx] = 1'b1;
                end else begin
                    d.ptr[fidx] = q.ptr[fidx] + PT_W'(1);
                end
            end else begin
                d.err = 1'b1;
            end
        end

        // access-control reset wins over phase, key and slot state in flight; a bus answer or a kat_start raised in the same cycle still goes out
        if (acr_req) begin
            d.kreg  = '0;
            d.full  = '0;
            d.ptr   = '0;
            d.grant = 1'b0;
            d.phase = ST_ZERO;
            d.zcnt  = '0;
        end
    end

    // everything clears at once; the sweep then runs regardless
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==================================================================
    // digest check
    hash_match #(
        .HW (HW)
    ) u_match (
        .clk        (clk),
        .rst_n      (rst_n),
        .clr        (acr_req),
        .hash_valid (hash_valid),
        .image_hash (image_hash),
        .otp_hash   (otp_hash),
        .checked    (hash_checked),
        .verified   (key_verified)
    );

    // ==================================================================
    // outputs: status only, key words have no route to a port
    // keys come from host writes alone, nothing here derives one
    assign bus_ack    = q.ack;
    assign bus_err    = q.err;
    assign bus_rdata  = q.rdata;
    assign kat_start  = q.kat_start;
    assign op_grant   = q.grant;
    assign key_loaded = q.full;
    assign ready      = (q.phase == ST_READY);
    assign locked     = (q.phase == ST_LOCK);

endmodule : secure_key_store
